// ===== dv/monitor_start_lock_control_tb_top.sv
`timescale 1ns/1ps
module monitor_start_lock_control_tb_top;
  import mslc_pkg::*;
  logic        i_mclk, i_reset, i_limit_wr, i_tach_update, i_status_event;
  mslc_req_s   i_req;
  logic [23:0] i_duty;
  logic [7:0]  o_rdata, q;
  logic        o_rvalid, o_limit_wr_en, o_status_set_en, o_tach_update_en;
  logic        o_reading_update_en, o_use_defaults, st, lk, ov;
  mslc_run_s   o_run;
  logic [2:0]  o_pwm;
  int          num_errors, samples_checked, cyc;
  localparam int SETTLE = 20;
  mslc_control #(.NUM_PWM(3), .SETTLE_CYC(SETTLE)) i_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_limit_wr(i_limit_wr), .o_limit_wr_en(o_limit_wr_en),
    .i_tach_update(i_tach_update), .i_status_event(i_status_event),
    .o_status_set_en(o_status_set_en), .o_tach_update_en(o_tach_update_en),
    .o_reading_update_en(o_reading_update_en), .o_use_defaults(o_use_defaults),
    .o_run(o_run), .i_duty(i_duty), .o_pwm(o_pwm));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmpb(input logic g, e);
    cmp({7'h0, g}, {7'h0, e});
  endtask
  function automatic logic [7:0] ctl();
    return {4'h0, ov, 1'b1, lk, st};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    i_req = '{1'b1, 1'b0, a, d};
    @(negedge i_mclk);
    i_req.wr = 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_mclk);
    cmpb(o_rvalid, 1'b1);
    cmp(o_rdata, e);
    i_req.rd = 1'b0;
    @(negedge i_mclk);
    cmpb(o_rvalid, 1'b0);
  endtask
  // one-cycle pulses on every event input, results one cycle later
  task automatic ev();
    i_limit_wr = 1'b1;
    i_status_event = 1'b1;
    i_tach_update = 1'b1;
    @(negedge i_mclk);
    i_limit_wr = 1'b0;
    i_status_event = 1'b0;
    i_tach_update = 1'b0;
    cmpb(o_limit_wr_en, !lk);
    cmpb(o_status_set_en, st);
    cmpb(o_tach_update_en, 1'b1);
    cmpb(o_use_defaults, !st);
    cmpb(o_reading_update_en, st);
    cmp({4'h0, o_run[4:1]}, {4'h0, st, lk, 1'b1, ov});
  endtask
  task automatic rnd(input int n);
    repeat (n)
    begin
      q = 8'($urandom) & 8'hfd;
      i_duty = 24'($urandom);
      wr(MSLC_OFS_CONTROL, q);
      st = q[0];
      ov = q[3];
      rd(MSLC_OFS_CONTROL, ctl());
      ev();
    end
  endtask
  // forced duty: all outputs high 255 of every 256 clocks
  task automatic pwm_chk();
    int h = 0;
    repeat (256)
    begin
      @(negedge i_mclk);
      h += int'(o_pwm === 3'h7);
    end
    cmp(8'(h), 8'hff);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    i_reset = 1'b1;
    i_req = '0;
    i_limit_wr = 1'b0;
    i_tach_update = 1'b0;
    i_status_event = 1'b0;
    i_duty = '0;
    {st, lk, ov} = 3'h0;
    void'($urandom(32'h66b9773a));
    repeat (6) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (20) @(negedge i_mclk);
    rd(MSLC_OFS_VERSION, {MSLC_VERSION_NIB, MSLC_STEPPING_NIB});
    rd(MSLC_OFS_CONTROL, 8'h04);
    ev();
    pwm_chk();
    wr(MSLC_OFS_VERSION, 8'h00);
    rd(MSLC_OFS_VERSION, {MSLC_VERSION_NIB, MSLC_STEPPING_NIB});
    rd(8'h41, 8'h00);
    wr(MSLC_OFS_CONTROL, 8'h01);
    st = 1'b1;
    repeat (SETTLE - 2) @(negedge i_mclk);
    cmpb(o_run.monitor_valid, 1'b0);
    @(negedge i_mclk);
    cmpb(o_run.monitor_valid, 1'b1);
    wr(MSLC_OFS_CONTROL, 8'h00);
    st = 1'b0;
    cmpb(o_run.monitor_valid, 1'b0);
    rnd(12);
    wr(MSLC_OFS_CONTROL, 8'h09);
    {st, ov} = 2'h3;
    pwm_chk();
    wr(MSLC_OFS_CONTROL, 8'hf3);
    {st, lk, ov} = 3'h6;
    rd(MSLC_OFS_CONTROL, ctl());
    ev();
    wr(MSLC_OFS_CONTROL, 8'h08);
    {st, ov} = 2'h1;
    rd(MSLC_OFS_CONTROL, ctl());
    rnd(12);
    stop_test();
  end
endmodule

// ===== dv/mslc_control_chk.sv
`timescale 1ns/1ps
module mslc_control_chk
  import mslc_pkg::*;
#(
  parameter int NUM_PWM = 3
)
(
  input wire logic         i_mclk,
  input wire logic         i_reset,
  input wire mslc_req_s    i_req,
  input wire logic [7:0]   o_rdata,
  input wire logic         i_limit_wr,
  input wire logic         o_limit_wr_en,
  input wire logic         i_tach_update,
  input wire logic         o_tach_update_en,
  input wire logic         o_status_set_en,
  input wire logic         o_use_defaults,
  input wire mslc_run_s    o_run,
  input wire logic [NUM_PWM-1:0] o_pwm
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////////
  property p_id;
    i_req.rd && i_req.addr == MSLC_OFS_VERSION |=> o_rdata == {MSLC_VERSION_NIB, MSLC_STEPPING_NIB};
  endproperty
  a_id: assert property (p_id)
    else $error("id read wrong");
  property p_rsv;
    i_req.rd && i_req.addr == MSLC_OFS_CONTROL |=> o_rdata[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_start;
    i_req.wr && i_req.addr == MSLC_OFS_CONTROL |=> o_run.start == $past(i_req.wdata[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("start not written");
  property p_lock;
    o_run.lock |=> o_run.lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock cleared");
  property p_lkwr;
    o_run.lock && i_limit_wr |=> !o_limit_wr_en;
  endproperty
  a_lkwr: assert property (p_lkwr)
    else $error("limit write while locked");
  property p_wren;
    !o_run.lock && i_limit_wr && !i_req.wr |=> o_limit_wr_en;
  endproperty
  a_wren: assert property (p_wren)
    else $error("limit write blocked");
  property p_def;
    o_use_defaults != o_run.start;
  endproperty
  a_def: assert property (p_def)
    else $error("defaults select wrong");
  property p_stat;
    !o_run.start && !i_req.wr |=> !o_status_set_en;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status set while stopped");
  property p_tach;
    i_tach_update |=> o_tach_update_en;
  endproperty
  a_tach: assert property (p_tach)
    else $error("tach update lost");
  property p_full;
    !o_run.start && !$past(o_run.start) && $fell(o_pwm[0]) |=> o_pwm[0];
  endproperty
  a_full: assert property (p_full)
    else $error("forced pwm low too long");
  cover property ($rose(o_run.lock));
  cover property ($rose(o_run.start));
  cover property (o_run.start && o_run.full_duty_override);
endmodule
bind mslc_control mslc_control_chk #(.NUM_PWM(NUM_PWM)) i_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
  .i_limit_wr(i_limit_wr), .o_limit_wr_en(o_limit_wr_en), .i_tach_update(i_tach_update),
  .o_tach_update_en(o_tach_update_en), .o_status_set_en(o_status_set_en),
  .o_use_defaults(o_use_defaults), .o_run(o_run), .o_pwm(o_pwm));

// ===== include/mslc_pkg.sv
package mslc_pkg;

  // register map
  localparam logic [7:0] MSLC_OFS_VERSION  = 8'h3f;
  localparam logic [7:0] MSLC_OFS_CONTROL  = 8'h40;

  // control register field positions
  localparam int         MSLC_BIT_START    = 0;
  localparam int         MSLC_BIT_LOCK     = 1;
  localparam int         MSLC_BIT_READY    = 2;
  localparam int         MSLC_BIT_OVERRIDE = 3;
  localparam logic [7:0] MSLC_CONTROL_RST  = 8'h00;

  // identification fields (values arbitrary)
  localparam logic [3:0] MSLC_VERSION_NIB  = 4'h3;
  localparam logic [3:0] MSLC_STEPPING_NIB = 4'h1;

  // timing
  localparam int         MSLC_CLK_MHZ      = 200;
  localparam int         MSLC_SETTLE_MS    = 82;
  localparam int         MSLC_SETTLE_CYC   = MSLC_SETTLE_MS * 1000 * MSLC_CLK_MHZ;
  localparam int         MSLC_READY_CYC    = 16;

  // pwm full-duty pattern
  localparam logic [7:0] MSLC_DUTY_FULL    = 8'hff;

  // register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mslc_req_s;

  // run state handed to monitoring and pwm logic
  typedef struct packed {
    logic start;
    logic lock;
    logic ready;
    logic full_duty_override;
    logic monitor_valid;
  } mslc_run_s;

  typedef enum logic [1:0] {
    MSLC_IDLE,
    MSLC_SETTLE,
    MSLC_RUN
  } mslc_state_e;

endpackage

// ===== verilog/mslc_control.sv
`timescale 1ns/1ps
module mslc_control
  import mslc_pkg::*;
#(
  parameter int NUM_PWM    = 3,
  parameter int SETTLE_CYC = MSLC_SETTLE_CYC
)
(
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_reset,
  // register port
  input  wire mslc_req_s          i_req,
  output logic [7:0]              o_rdata,
  output logic                    o_rvalid,
  // limit register write gating
  input  wire logic               i_limit_wr,
  output logic                    o_limit_wr_en,
  // monitoring
  input  wire logic               i_tach_update,
  input  wire logic               i_status_event,
  output logic                    o_status_set_en,
  output logic                    o_tach_update_en,
  output logic                    o_reading_update_en,
  output logic                    o_use_defaults,
  output mslc_run_s               o_run,
  // pwm
  input  wire logic [NUM_PWM*8-1:0] i_duty,
  output logic [NUM_PWM-1:0]      o_pwm
);

  ////////////////////////////////////////////////////////////////////////
  // control register fields

  logic        start_r;
  logic        start_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic        ovr_r;
  logic        ovr_nxt;
  logic        ctrl_wr;

  // one decoder for the write strobe and the read mux
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction

  assign ctrl_wr = i_req.wr && reg_hit(i_req.addr, MSLC_OFS_CONTROL);

  always_comb
  begin
    start_nxt = start_r;
    lock_nxt  = lock_r;
    ovr_nxt   = ovr_r;
    if (ctrl_wr)
    begin
      start_nxt = i_req.wdata[MSLC_BIT_START];
      ovr_nxt   = i_req.wdata[MSLC_BIT_OVERRIDE];
      // lock is sticky: once set, later writes cannot clear it
      if (!lock_r)
        lock_nxt = i_req.wdata[MSLC_BIT_LOCK];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      start_r <= MSLC_CONTROL_RST[MSLC_BIT_START];
      lock_r  <= MSLC_CONTROL_RST[MSLC_BIT_LOCK];
      ovr_r   <= MSLC_CONTROL_RST[MSLC_BIT_OVERRIDE];
    end
    else
    begin
      start_r <= start_nxt;
      lock_r  <= lock_nxt;
      ovr_r   <= ovr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up ready flag

  logic       ready_r;
  logic       ready_nxt;
  logic [4:0] rdy_cnt_r;
  logic [4:0] rdy_cnt_nxt;

  always_comb
  begin
    ready_nxt   = ready_r;
    rdy_cnt_nxt = rdy_cnt_r;
    // ready after internal power-up settle; software cannot touch it
    if (!ready_r)
    begin
      if (rdy_cnt_r == 5'(MSLC_READY_CYC - 1))
        ready_nxt = 1'b1;
      else
        rdy_cnt_nxt = rdy_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      ready_r   <= 1'b0;
      rdy_cnt_r <= 5'h00;
    end
    else
    begin
      ready_r   <= ready_nxt;
      rdy_cnt_r <= rdy_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settle timer: readings valid a fixed time after start

  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  logic [SETTLE_W-1:0] settle_r;
  logic [SETTLE_W-1:0] settle_nxt;
  mslc_state_e         state_r;
  mslc_state_e         state_nxt;

  always_comb
  begin
    settle_nxt = settle_r;
    state_nxt  = state_r;
    unique case (state_r)
      MSLC_IDLE:
      begin
        if (start_nxt)
        begin
          state_nxt  = MSLC_SETTLE;
          settle_nxt = '0;
        end
      end
      MSLC_SETTLE:
      begin
        // a cleared start drops back and restarts the wait
        if (!start_nxt)
          state_nxt = MSLC_IDLE;
        else if (settle_r == SETTLE_W'(SETTLE_CYC - 1))
          state_nxt = MSLC_RUN;
        else
          settle_nxt = settle_r + SETTLE_W'(1);
      end
      MSLC_RUN:
      begin
        if (!start_nxt)
          state_nxt = MSLC_IDLE;
      end
      // the two-bit code has one unused value
      default:
      begin
        state_nxt  = MSLC_IDLE;
        settle_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      settle_r <= '0;
      state_r  <= MSLC_IDLE;
    end
    else
    begin
      settle_r <= settle_nxt;
      state_r  <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  function automatic logic [7:0] rd_mux(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (reg_hit(addr, MSLC_OFS_VERSION))
      v = {MSLC_VERSION_NIB, MSLC_STEPPING_NIB};
    else if (reg_hit(addr, MSLC_OFS_CONTROL))
      v = {4'h0, ovr_r, ready_r, lock_r, start_r};
    return v;
  endfunction

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  always_comb
  begin
    rvalid_nxt = i_req.rd;
    rdata_nxt  = i_req.rd ? rd_mux(i_req.addr) : rdata_r;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse enables to limit, status and tachometer logic

  logic limit_en_r;
  logic limit_en_nxt;
  logic status_en_r;
  logic status_en_nxt;
  logic tach_en_r;
  logic tach_en_nxt;

  always_comb
  begin
    // only lock blocks limit writes; storage untouched by start
    limit_en_nxt  = i_limit_wr && !lock_nxt;
    status_en_nxt = start_nxt && i_status_event;
    tach_en_nxt   = i_tach_update;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      limit_en_r  <= 1'b0;
      status_en_r <= 1'b0;
      tach_en_r   <= 1'b0;
    end
    else
    begin
      limit_en_r  <= limit_en_nxt;
      status_en_r <= status_en_nxt;
      tach_en_r   <= tach_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reading update and default-limit selects

  logic read_en_r;
  logic read_en_nxt;
  logic defaults_r;
  logic defaults_nxt;

  always_comb
  begin
    // readings frozen until start, then updated
    read_en_nxt  = start_nxt;
    defaults_nxt = !start_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      read_en_r  <= 1'b0;
      defaults_r <= 1'b1;
    end
    else
    begin
      read_en_r  <= read_en_nxt;
      defaults_r <= defaults_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run state handed to monitoring and pwm logic

  mslc_run_s run_r;
  mslc_run_s run_nxt;

  always_comb
  begin
    run_nxt.start              = start_nxt;
    run_nxt.lock               = lock_nxt;
    run_nxt.ready              = ready_nxt;
    run_nxt.full_duty_override = ovr_nxt;
    run_nxt.monitor_valid      = (state_nxt == MSLC_RUN);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      run_r <= '0;
    else
      run_r <= run_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm outputs

  logic force_full;

  assign force_full = !start_r || ovr_r;

  genvar g;
  generate
    for (g = 0; g < NUM_PWM; g++)
    begin : g_pwm
      mslc_pwm_gate u_pwm (
        .i_mclk       (i_mclk),
        .i_reset      (i_reset),
        .i_force_full (force_full),
        .i_duty       (i_duty[g*8 +: 8]),
        .o_pwm        (o_pwm[g])
      );
    end
  endgenerate

  assign o_rdata             = rdata_r;
  assign o_rvalid            = rvalid_r;
  assign o_limit_wr_en       = limit_en_r;
  assign o_status_set_en     = status_en_r;
  assign o_tach_update_en    = tach_en_r;
  assign o_reading_update_en = read_en_r;
  assign o_use_defaults      = defaults_r;
  assign o_run               = run_r;

endmodule

// ===== verilog/mslc_pwm_gate.sv
`timescale 1ns/1ps
module mslc_pwm_gate
  import mslc_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // control
  input  wire logic       i_force_full,
  input  wire logic [7:0] i_duty,
  // pwm output
  output logic            o_pwm
);

  logic [7:0] phase_r;
  logic [7:0] phase_nxt;
  logic       pwm_r;
  logic       pwm_nxt;

  always_comb
  begin
    phase_nxt = phase_r + 8'h01;
    // full duty: high 255 clocks, low 1 clock
    if (i_force_full)
      pwm_nxt = (phase_r != MSLC_DUTY_FULL);
    else
      pwm_nxt = (phase_r < i_duty);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      phase_r <= 8'h00;
      pwm_r   <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      pwm_r   <= pwm_nxt;
    end
  end

  assign o_pwm = pwm_r;

endmodule
